/* veil_cmd_handler.v */
// Purpose: Tag-side handler for the veil and unveil memory commands.
// Assumes: The air-link front end delivers demodulated command bits and
//          sends reply bits; it handles the frame sync and preamble itself.
// Notes:   The protection bits are kept by a nonvolatile store outside.
// Summary of operation
// - Valid veil in secured sets both bits.
// - Set bits hide protected memory from reads.
// - Zero access password: ignore veil silently.
// - Reply: zero header, handle, CRC-16.
// - Protection applies only after veil reply ends.
// - Failure sends error code instead of reply.
// - Replies always use the extended preamble.
// - Veil frame: code, handle, CRC-16.
// - Veil silent outside secured; documented state moves.
// - Secured veil: password and handle decide outcome.
// - Successful unveil clears both protection bits.
// - Unveil frame: code, covered password, handle, CRC.
// - Password is uncovered with doubled RN16.
// - Unveil accepted in open and secured.
// - Protection bits live in nonvolatile memory.
`timescale 1ns/100ps
`include "veil_defines.vh"
module veil_cmd_handler #(
  parameter HANDLE_W = 16,
  parameter PWD_W    = 32
) (
  // Clock and reset.
  input  wire                clk_i,
  input  wire                sys_rst_i,
  // Incoming command bits, framed by frame_start and frame_end.
  input  wire                frame_start_i,
  input  wire                rx_valid_i,
  input  wire                rx_bit_i,
  input  wire                frame_end_i,
  // Session context from the rest of the tag.
  input  wire [2:0]          tag_state_i,
  input  wire [HANDLE_W-1:0] handle_i,
  input  wire [HANDLE_W-1:0] rn16_i,
  input  wire [PWD_W-1:0]    access_pwd_i,
  input  wire                nvm_ready_i,
  input  wire                nvm_fail_i,
  // Nonvolatile protection bits, loaded at power-up.
  input  wire                nvm_epc_veil_i,
  input  wire                nvm_tid_veil_i,
  input  wire                nvm_valid_i,
  // Reads of protected areas ask here.
  input  wire                epc_read_i,
  input  wire                tid_read_i,
  output wire                epc_read_hide_o,
  output wire                tid_read_hide_o,
  // Nonvolatile write request.
  output reg                 nvm_write_o,
  output reg                 nvm_value_o,
  // State change request to the protocol core.
  output reg                 state_load_o,
  output reg  [2:0]          state_next_o,
  // Reply bit stream.
  output reg                 tx_start_o,
  output reg                 tx_valid_o,
  output reg                 tx_bit_o,
  output reg                 tx_trext_o,
  output reg                 tx_error_o,
  // Current protection bits.
  output reg                 epc_read_veil_bit_o,
  output reg                 tid_read_veil_bit_o
);
  // Receive, decide, wait for the store, then send the reply; for a veil the
  // protection is raised only once the last reply bit is out.
  localparam S_IDLE  = 3'h0;
  localparam S_RECV  = 3'h1;
  localparam S_EXEC  = 3'h2;
  localparam S_NVM   = 3'h3;
  localparam S_REPLY = 3'h4;
  localparam S_CRC   = 3'h5;
  localparam S_APPLY = 3'h6;

  reg [2:0]  fsm_reg;
  reg [79:0] shift_reg;
  reg [6:0]  count_reg;
  reg [5:0]  tx_count_reg;
  reg        veil_op_reg;
  reg [HANDLE_W-1:0] reply_sh_reg;
  reg [15:0] crc_sh_reg;

  wire [15:0] crc_val;
  wire        crc_ok;
  reg         crc_load;
  reg         crc_shift;
  reg         crc_in;
  wire        frame_take = frame_start_i && (fsm_reg == S_IDLE);

  reply_crc16 u_crc (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .load_i       (crc_load),
    .shift_i      (crc_shift),
    .bit_i        (crc_in),
    .crc_o        (crc_val),
    .residue_ok_o (crc_ok)
  );

  // Reply CRC reuses the same engine, header zero then handle. A frame start
  // seen while busy must not preset it, or a reply in flight would carry a
  // broken checksum.
  always @* begin
    crc_load  = frame_take || (fsm_reg == S_NVM && nvm_ready_i);
    crc_shift = 1'b0;
    crc_in    = 1'b0;
    if (fsm_reg == S_RECV && rx_valid_i) begin
      crc_shift = 1'b1;
      crc_in    = rx_bit_i;
    end else if (fsm_reg == S_REPLY) begin
      crc_shift = 1'b1;
      crc_in    = (tx_count_reg == 6'd0) ? 1'b0 : reply_sh_reg[HANDLE_W-1];
    end
  end

  // Undo the cover with the current random number doubled to full width.
  function pwd_match;
    input [PWD_W-1:0] covered;
    input [PWD_W-1:0] stored;
    input [HANDLE_W-1:0] rn;
    begin
      pwd_match = ((covered ^ {rn, rn}) == stored);
    end
  endfunction

  // Sixteen-bit field of the received frame, counted from its last bit.
  function [15:0] field16;
    input [79:0] frame;
    input [6:0]  lsb;
    begin
      field16 = frame[lsb +: 16];
    end
  endfunction

  // Only the low bits of the shift register hold a short frame; the stale
  // upper part is never compared, since the length is checked first.
  wire is_veil   = (count_reg == `VEIL_FRAME_BITS) &&
                   (field16(shift_reg, `VEIL_CODE_LSB) == `VEIL_CODE);
  wire is_unveil = (count_reg == `UNVEIL_FRAME_BITS) &&
                   (field16(shift_reg, `UNVEIL_CODE_LSB) == `UNVEIL_CODE);
  wire [HANDLE_W-1:0] rx_handle = shift_reg[`HANDLE_LSB +: HANDLE_W];
  wire handle_ok = (rx_handle == handle_i);
  wire unveil_pwd_ok = pwd_match(shift_reg[`PWD_LSB +: PWD_W], access_pwd_i, rn16_i);
  wire pwd_zero = (access_pwd_i == {PWD_W{1'b0}});
  wire in_sel   = (tag_state_i == `ST_ARBITRATE) || (tag_state_i == `ST_REPLY) ||
                  (tag_state_i == `ST_ACK);
  // Outcome of a frame whose check has passed. The selected states fall back
  // to arbitrate for either command without looking at handle or password.
  wire frame_good   = crc_ok && (is_veil || is_unveil);
  wire veil_take    = is_veil && (tag_state_i == `ST_SECURED) && !pwd_zero &&
                      handle_ok;
  wire unveil_state = (tag_state_i == `ST_OPEN) || (tag_state_i == `ST_SECURED);
  wire unveil_take  = is_unveil && unveil_state && handle_ok && unveil_pwd_ok;
  wire unveil_deny  = is_unveil && unveil_state && handle_ok && !unveil_pwd_ok;

  assign epc_read_hide_o = epc_read_i && epc_read_veil_bit_o;
  assign tid_read_hide_o = tid_read_i && tid_read_veil_bit_o;

  // The stored copy of the protection bits is reloaded whenever the store
  // reports it valid. A command that sets or clears them assigns later in
  // this process, so its result wins over a reload in the same cycle.
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fsm_reg             <= S_IDLE;
      shift_reg           <= 80'h0;
      count_reg           <= 7'h0;
      tx_count_reg        <= 6'h0;
      veil_op_reg         <= 1'b0;
      reply_sh_reg        <= {HANDLE_W{1'b0}};
      crc_sh_reg          <= 16'h0000;
      nvm_write_o         <= 1'b0;
      nvm_value_o         <= 1'b0;
      state_load_o        <= 1'b0;
      state_next_o        <= `ST_READY;
      tx_start_o          <= 1'b0;
      tx_valid_o          <= 1'b0;
      tx_bit_o            <= 1'b0;
      tx_trext_o          <= 1'b0;
      tx_error_o          <= 1'b0;
      epc_read_veil_bit_o <= 1'b0;
      tid_read_veil_bit_o <= 1'b0;
    end else begin
      nvm_write_o  <= 1'b0;
      state_load_o <= 1'b0;
      tx_start_o   <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_error_o   <= 1'b0;
      if (nvm_valid_i) begin
        epc_read_veil_bit_o <= nvm_epc_veil_i;
        tid_read_veil_bit_o <= nvm_tid_veil_i;
      end
      case (fsm_reg)
        S_IDLE: begin
          if (frame_take) begin
            count_reg <= 7'h0;
            fsm_reg   <= S_RECV;
          end
        end
        S_RECV: begin
          // Bits past the longest frame are dropped and the count holds there; the frame check still covers every bit.
          if (rx_valid_i && count_reg != `UNVEIL_FRAME_BITS) begin
            shift_reg <= {shift_reg[78:0], rx_bit_i};
            count_reg <= count_reg + 7'd1;
          end
          if (frame_end_i) begin
            fsm_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          fsm_reg <= S_IDLE;
          // A frame with a bad check or unknown code changes nothing.
          if (frame_good) begin
            if (in_sel) begin
              state_load_o <= 1'b1;
              state_next_o <= `ST_ARBITRATE;
            end else if (veil_take) begin
              veil_op_reg <= 1'b1;
              nvm_value_o <= 1'b1;
              nvm_write_o <= 1'b1;
              fsm_reg     <= S_NVM;
            end else if (unveil_take) begin
              veil_op_reg <= 1'b0;
              nvm_value_o <= 1'b0;
              nvm_write_o <= 1'b1;
              fsm_reg     <= S_NVM;
            end else if (unveil_deny) begin
              // A wrong password ends the session and sends the tag to arbitrate.
              state_load_o <= 1'b1;
              state_next_o <= `ST_ARBITRATE;
            end
          end
        end
        S_NVM: begin
          // No timeout here: the store always answers with ready or fail, and
          // keeping the carrier limit is the reader's duty.
          if (nvm_fail_i) begin
            // A failed write leaves the protection bits as they were.
            tx_start_o <= 1'b1;
            tx_error_o <= 1'b1;
            tx_trext_o <= 1'b1;
            fsm_reg    <= S_IDLE;
          end else if (nvm_ready_i) begin
            tx_start_o   <= 1'b1;
            // The extended preamble flag is left set, since every reply of this
            // block needs it; the front end reads it only when a reply starts.
            tx_trext_o   <= 1'b1;
            reply_sh_reg <= handle_i;
            tx_count_reg <= 6'h0;
            if (!veil_op_reg) begin
              epc_read_veil_bit_o <= 1'b0;
              tid_read_veil_bit_o <= 1'b0;
            end
            fsm_reg <= S_REPLY;
          end
        end
        S_REPLY: begin
          tx_valid_o <= 1'b1;
          if (tx_count_reg == 6'd0) begin
            tx_bit_o <= 1'b0;
          end else begin
            tx_bit_o     <= reply_sh_reg[HANDLE_W-1];
            reply_sh_reg <= {reply_sh_reg[HANDLE_W-2:0], 1'b0};
          end
          tx_count_reg <= tx_count_reg + 6'd1;
          if (tx_count_reg == `REPLY_CRC_FIRST - 6'd1) begin
            fsm_reg <= S_CRC;
          end
        end
        S_CRC: begin
          if (tx_count_reg == `REPLY_CRC_FIRST) begin
            crc_sh_reg <= {~crc_val[14:0], 1'b0};
            tx_bit_o   <= ~crc_val[15];
          end else begin
            crc_sh_reg <= {crc_sh_reg[14:0], 1'b0};
            tx_bit_o   <= crc_sh_reg[15];
          end
          tx_valid_o   <= 1'b1;
          tx_count_reg <= tx_count_reg + 6'd1;
          if (tx_count_reg == `REPLY_BITS - 6'd1) begin
            fsm_reg <= S_APPLY;
          end
        end
        S_APPLY: begin
          if (veil_op_reg) begin
            epc_read_veil_bit_o <= 1'b1;
            tid_read_veil_bit_o <= 1'b1;
          end
          fsm_reg <= S_IDLE;
        end
        default: begin
          fsm_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* veil_defines.vh */
// Purpose: Constants for the veil/unveil command handler.
// Assumes: Frames arrive as serial bits, MSB first, already demodulated.
// Notes:   Tag states follow the usual air-interface protocol states.
`ifndef VEIL_DEFINES_VH
`define VEIL_DEFINES_VH
`define VEIL_CODE        16'hE001
`define UNVEIL_CODE      16'hE002
`define VEIL_FRAME_BITS  7'd48
`define UNVEIL_FRAME_BITS 7'd80
`define CRC_INIT         16'hFFFF
`define CRC_RESIDUE      16'h1D0F
`define CRC_POLY         16'h1021
`define REPLY_BITS       6'd33
`define REPLY_CRC_FIRST  6'd17
`define VEIL_CODE_LSB    7'd32
`define UNVEIL_CODE_LSB  7'd64
`define PWD_LSB          7'd32
`define HANDLE_LSB       7'd16
`define ST_READY         3'h0
`define ST_ARBITRATE     3'h1
`define ST_REPLY         3'h2
`define ST_ACK           3'h3
`define ST_OPEN          3'h4
`define ST_SECURED       3'h5
`define ST_KILLED        3'h6
`endif

/* reply_crc16.v */
// Purpose: Serial CRC-16 engine used for both frame check and reply.
// Assumes: One bit per clock when shift_i is high.
// Notes:   Load presets the register; the check compares with the residue.
`timescale 1ns/100ps
`include "veil_defines.vh"
module reply_crc16 (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // Control.
  input  wire        load_i,
  input  wire        shift_i,
  input  wire        bit_i,
  // Result.
  output wire [15:0] crc_o,
  output wire        residue_ok_o
);
  reg  [15:0] crc_reg;
  wire        fb = crc_reg[15] ^ bit_i;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      crc_reg <= `CRC_INIT;
    end else if (load_i) begin
      crc_reg <= `CRC_INIT;
    end else if (shift_i) begin
      crc_reg <= {crc_reg[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
  end
  assign crc_o        = crc_reg;
  assign residue_ok_o = (crc_reg == `CRC_RESIDUE);
endmodule

/* veil_props.sv */
// Purpose: Port assertions for the veil command handler.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound to every handler instance.
`timescale 1ns/100ps
module veil_props (
  // Clock and reset.
  input logic clk_i,
  input logic sys_rst_i,
  // Watched inputs.
  input logic frame_end_i,
  input logic nvm_ready_i,
  input logic nvm_fail_i,
  input logic nvm_valid_i,
  input logic epc_read_i,
  // Watched outputs.
  input logic epc_read_hide_o,
  input logic nvm_write_o,
  input logic tx_start_o,
  input logic tx_valid_o,
  input logic tx_bit_o,
  input logic tx_trext_o,
  input logic tx_error_o,
  input logic epc_read_veil_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wr_after_end_a: assert property (nvm_write_o |-> $past(frame_end_i, 2))
    else $error("store write without a closed frame");
  start_cause_a: assert property (tx_start_o |-> $past(nvm_ready_i) || $past(nvm_fail_i))
    else $error("reply started without store result");
  header_zero_a: assert property (tx_start_o && !tx_error_o |=> tx_valid_o && !tx_bit_o)
    else $error("reply header is not zero");
  reply_run_a: assert property (tx_start_o && !tx_error_o |=> tx_valid_o [*8])
    else $error("reply bits not consecutive");
  err_cause_a: assert property (tx_error_o |-> tx_start_o && $past(nvm_fail_i))
    else $error("error reply without store failure");
  trext_on_a: assert property (tx_valid_o |-> tx_trext_o)
    else $error("reply without extended preamble");
  veil_late_a: assert property ($rose(epc_read_veil_bit_o)
    |-> $past(tx_valid_o) || $past(nvm_valid_i))
    else $error("protection set before reply ended");
  clear_time_a: assert property ($fell(epc_read_veil_bit_o)
    |-> tx_start_o || $past(tx_start_o) || $past(nvm_valid_i))
    else $error("protection cleared outside a reply");
  hide_read_a: assert property (epc_read_i && epc_read_veil_bit_o |-> epc_read_hide_o)
    else $error("protected read not hidden");
  cover property (tx_start_o && !tx_error_o);
  cover property (tx_error_o);
  cover property ($fell(epc_read_veil_bit_o));
endmodule
bind veil_cmd_handler veil_props chk (.clk_i, .sys_rst_i, .frame_end_i, .nvm_ready_i,
  .nvm_fail_i, .nvm_valid_i, .epc_read_i, .epc_read_hide_o, .nvm_write_o, .tx_start_o,
  .tx_valid_o, .tx_bit_o, .tx_trext_o, .tx_error_o, .epc_read_veil_bit_o);

/* reader_model.sv */
// Purpose: Interrogator model sending command frames bit by bit.
// Assumes: One bit per clock, MSB first.
// Notes:   The released data line shows the inverse of its last bit.
`timescale 1ns/100ps
`include "veil_defines.vh"
module reader_model (
  // Clock.
  input  logic clk_i,
  // Command bits towards the tag.
  output logic frame_start_o,
  output logic rx_valid_o,
  output logic rx_bit_o,
  output logic frame_end_o
);
  function automatic [15:0] crc16(input [63:0] d, input [6:0] n);
    reg     [15:0] c;
    integer        i;
    begin
      c = `CRC_INIT;
      for (i = n - 1; i >= 0; i = i - 1)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
      crc16 = c;
    end
  endfunction
  initial begin
    frame_start_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_bit_o = 1'b0;
    frame_end_o = 1'b0;
  end
  task send(input [63:0] body, input [6:0] n, input bad);
    reg     [79:0] f;
    integer        i;
    begin
      f = {body, ~crc16(body, n) ^ {15'h0000, bad}};
      @(posedge clk_i) frame_start_o <= 1'b1;
      @(posedge clk_i) frame_start_o <= 1'b0;
      for (i = n + 15; i >= 0; i = i - 1) begin
        rx_valid_o <= 1'b1;
        rx_bit_o <= f[i];
        @(posedge clk_i);
      end
      rx_valid_o <= 1'b0;
      rx_bit_o <= ~f[0];
      frame_end_o <= 1'b1;
      @(posedge clk_i) frame_end_o <= 1'b0;
    end
  endtask
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the veil command handler.
// Assumes: The store answers one cycle after each write request.
// Notes:   A fixed listening window stands in for the carrier limit.
`timescale 1ns/100ps
`include "veil_defines.vh"
`define CHK(nm, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
  num_errors = num_errors + 1; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  localparam [15:0] HND = 16'hA5C3;
  localparam [15:0] RN2 = 16'h3C96;
  localparam [31:0] PWD = 32'h1234_5678;
  reg           clk_i, sys_rst_i, tx_fail, epc_read_i, tid_read_i, nvm_ready_i, nvm_fail_i;
  reg           nvm_epc_veil_i, nvm_tid_veil_i, nvm_valid_i;
  reg  [2:0]    tag_state_i, last_st;
  reg  [15:0]   handle_i, rn16_i;
  reg  [31:0]   access_pwd_i;
  reg  [32:0]   got;
  reg           wval;
  integer       nbits, nwr, nstart, nerr, nload, num_errors, num_checks;
  wire          frame_start_i, rx_valid_i, rx_bit_i, frame_end_i, epc_read_hide_o;
  wire          tid_read_hide_o, nvm_write_o, nvm_value_o, state_load_o, tx_start_o;
  wire          tx_valid_o, tx_bit_o, tx_trext_o, tx_error_o;
  wire          epc_read_veil_bit_o, tid_read_veil_bit_o;
  wire [2:0]    state_next_o;
  veil_cmd_handler DUT (.clk_i, .sys_rst_i, .frame_start_i, .rx_valid_i, .rx_bit_i,
    .frame_end_i, .tag_state_i, .handle_i, .rn16_i, .access_pwd_i, .nvm_ready_i, .nvm_fail_i,
    .nvm_epc_veil_i, .nvm_tid_veil_i, .nvm_valid_i, .epc_read_i,
    .tid_read_i, .epc_read_hide_o, .tid_read_hide_o, .nvm_write_o, .nvm_value_o,
    .state_load_o, .state_next_o, .tx_start_o, .tx_valid_o, .tx_bit_o, .tx_trext_o,
    .tx_error_o, .epc_read_veil_bit_o, .tid_read_veil_bit_o);
  reader_model rdr (.clk_i, .frame_start_o(frame_start_i), .rx_valid_o(rx_valid_i),
    .rx_bit_o(rx_bit_i), .frame_end_o(frame_end_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    nvm_ready_i <= nvm_write_o & ~tx_fail;
    nvm_fail_i <= nvm_write_o & tx_fail;
    if (tx_valid_o) begin
      got <= {got[31:0], tx_bit_o};
      nbits <= nbits + 1;
    end
    if (nvm_write_o) wval <= nvm_value_o;
    if (nvm_write_o) nwr <= nwr + 1;
    if (tx_error_o) nerr <= nerr + 1;
    if (tx_start_o) nstart <= nstart + 1;
    if (state_load_o) begin
      nload <= nload + 1;
      last_st <= state_next_o;
    end
  end
  task run(input [63:0] body, input [6:0] n, input bad, input [2:0] st);
    begin
      @(posedge clk_i);
      tag_state_i <= st;
      nbits = 0; nwr = 0; nerr = 0; nstart = 0; nload = 0;
      rdr.send(body, n, bad);
      repeat (60) @(posedge clk_i);
    end
  endtask
  task t_veil_ok;
    reg [32:0] exp;
    begin
      exp = {1'b0, HND, ~rdr.crc16({48'h0, HND}, 7'd17)};
      run({32'h0, `VEIL_CODE, HND}, 7'd32, 1'b0, `ST_SECURED);
      `CHK("store", 2'b11, {nwr[0], wval})
      `CHK("bits", 2'b11, {epc_read_veil_bit_o, tid_read_veil_bit_o})
      `CHK("reply", {6'd33, exp}, {nbits[5:0], got})
      `CHK("trext", 1'b1, tx_trext_o)
      `CHK("hide", 2'b11, {epc_read_hide_o, tid_read_hide_o})
      $display("veil_ok done");
    end
  endtask
  task t_unveil_bad;
    begin
      run({`UNVEIL_CODE, PWD ^ {rn16_i, rn16_i} ^ 32'h1, HND}, 7'd64, 1'b0, `ST_SECURED);
      `CHK("silent", 0, nstart)
      `CHK("arb", {4'd1, `ST_ARBITRATE}, {nload[3:0], last_st})
      `CHK("bits", 2'b11, {epc_read_veil_bit_o, tid_read_veil_bit_o})
      run({`UNVEIL_CODE, PWD ^ {rn16_i, rn16_i}, ~HND}, 7'd64, 1'b0, `ST_OPEN);
      `CHK("badhnd", {32'd0, 32'd0}, {nstart, nload})
      $display("unveil_bad done");
    end
  endtask
  task t_unveil_ok;
    reg [32:0] exp;
    begin
      exp = {1'b0, HND, ~rdr.crc16({48'h0, HND}, 7'd17)};
      @(posedge clk_i);
      rn16_i <= RN2;
      run({`UNVEIL_CODE, PWD ^ {RN2, RN2}, HND}, 7'd64, 1'b0, `ST_OPEN);
      `CHK("reply", {6'd33, exp}, {nbits[5:0], got})
      `CHK("bits", 4'b0000, {epc_read_veil_bit_o, tid_read_veil_bit_o, wval, nload[0]})
      `CHK("hide", 2'b00, {epc_read_hide_o, tid_read_hide_o})
      $display("unveil_ok done");
    end
  endtask
  task t_silent;
    integer s;
    reg     ok;
    reg     [2:0] st;
    begin
      // Five has a zero password, seven a wrong handle, eight a damaged checksum.
      for (s = 0; s < 9; s = s + 1) begin
        st = (s > 6) ? `ST_SECURED : s[2:0];
        access_pwd_i <= (s == 5) ? 32'h0 : PWD;
        run({32'h0, `VEIL_CODE, (s == 7) ? ~HND : HND}, 7'd32, s == 8, st);
        ok = (s >= 1 && s <= 3) ? (nload == 1 && last_st === `ST_ARBITRATE)
                                : (nload == 0 || last_st === st);
        `CHK("silent", 0, nstart)
        `CHK("bits", 2'b00, {epc_read_veil_bit_o, tid_read_veil_bit_o})
        `CHK("state", 1'b1, ok)
      end
      access_pwd_i <= PWD;
      $display("silent done");
    end
  endtask
  task t_nvm_fail;
    begin
      tx_fail = 1'b1;
      run({32'h0, `VEIL_CODE, HND}, 7'd32, 1'b0, `ST_SECURED);
      tx_fail = 1'b0;
      `CHK("error", 1, nerr)
      `CHK("bits", 2'b00, {epc_read_veil_bit_o, tid_read_veil_bit_o})
      $display("nvm_fail done");
    end
  endtask
  task t_nvm_load;
    begin
      @(posedge clk_i);
      nvm_epc_veil_i <= 1'b1;
      nvm_tid_veil_i <= 1'b1;
      nvm_valid_i    <= 1'b1;
      @(posedge clk_i);
      nvm_valid_i <= 1'b0;
      epc_read_i  <= 1'b0;
      @(posedge clk_i);
      `CHK("load", 2'b11, {epc_read_veil_bit_o, tid_read_veil_bit_o})
      `CHK("hide", 2'b01, {epc_read_hide_o, tid_read_hide_o})
      nvm_epc_veil_i <= 1'b0;
      nvm_tid_veil_i <= 1'b0;
      nvm_valid_i    <= 1'b1;
      @(posedge clk_i);
      nvm_valid_i <= 1'b0;
      epc_read_i  <= 1'b1;
      @(posedge clk_i);
      `CHK("reload", 2'b00, {epc_read_veil_bit_o, tid_read_veil_bit_o})
      `CHK("hide", 2'b00, {epc_read_hide_o, tid_read_hide_o})
      $display("nvm_load done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    sys_rst_i = 1'b1; tag_state_i = 3'h0; handle_i = HND; rn16_i = 16'h5A17;
    access_pwd_i = PWD; nvm_ready_i = 1'b0; nvm_fail_i = 1'b0; epc_read_i = 1'b1;
    tid_read_i = 1'b1; tx_fail = 1'b0; num_errors = 0; num_checks = 0; got = 33'h0;
    nvm_epc_veil_i = 1'b0; nvm_tid_veil_i = 1'b0; nvm_valid_i = 1'b0;
    wval = 1'b0; last_st = 3'h0; nbits = 0; nwr = 0; nerr = 0; nstart = 0; nload = 0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_veil_ok;
    t_unveil_bad;
    t_unveil_ok;
    t_silent;
    t_nvm_fail;
    t_nvm_load;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors = num_errors + 1;
    conclude;
  end
endmodule
